// *** src/gpc_regs.vh ***
// Constants shared by the dual counter/timer block.
//
// How it works
// (RL1) Two counters, each 32 bits wide.
// (RL2) Edge mode counts chosen source edge polarity.
// (RL3) Live count readable without disturbing counting.
// (RL4) Active gate pause blocks source edges.
// (RL5) Sample edge captures cumulative count, no clear.
// (RL6) Sample clock is gate, edge selectable.
// (RL7) Buffered edge counting starts at arm.
// (RL8) Direction: up, down, or direction input.
// (RL9) Pulse width counts edges while gate active.
// (RL10) Armed during active pulse waits next one.
// (RL11) Single width saves on trailing edge, stops.
// (RL12) Buffered width saves and queues each pulse.
// (RL13) Period counts between same-polarity gate edges.
// (RL14) Single period saves on second edge, stops.
// (RL15) Buffered period saves and queues each period.
// (RL16) Buffered period first value may be partial.
// (RL17) Buffered semi-period saves on every gate edge.
// (RL18) Single semi-period equals single pulse width.
// (RL19) Source should pulse between gate edges.
// (RL20) Frequency: signal on gate, timebase on source.
// (RL21) Seven selectable inputs per counter.
// (RL22) Count wraps modulo two to the 32.
// (RL23) Captures queued in order; overflow flagged.
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

// Measurement mode codes.
`define GPC_MODE_EDGE 3'h0
`define GPC_MODE_EDGE_BUF 3'h1
`define GPC_MODE_PW_ONE 3'h2
`define GPC_MODE_PW_BUF 3'h3
`define GPC_MODE_PER_ONE 3'h4
`define GPC_MODE_PER_BUF 3'h5
`define GPC_MODE_SEMI_ONE 3'h6
`define GPC_MODE_SEMI_BUF 3'h7

// Direction mode codes.
`define GPC_DIR_UP 2'h0
`define GPC_DIR_DOWN 2'h1
`define GPC_DIR_PIN 2'h2

// Sizes and reset values.
`define GPC_COUNT_W 32
`define GPC_NUM_INPUTS 7
`define GPC_FIFO_DEPTH 32
`define GPC_COUNT_RST 32'h00000000

`endif

// *** src/gpc_top.v ***
// Dual general-purpose counter/timer with capture queues.
`timescale 1ns/10ps
`include "gpc_regs.vh"

// ==========================================================
// Capture queue
// ==========================================================

// Simple synchronous FIFO; full and empty are exact.
module gpc_fifo #(
  parameter W = 32,
  parameter D = 32,
  parameter AW = 5
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem [0:D-1];
  reg [AW:0] wp;
  reg [AW:0] rp;
  wire [AW:0] used;
  wire wr_go;
  wire rd_go;

  // Pointers carry one extra bit so full and empty differ.
  assign used = wp - rp;
  assign in_ready_o = (used != D[AW:0]);
  assign out_valid_o = (used != {(AW+1){1'b0}});
  assign wr_go = in_valid_i & in_ready_o;
  assign rd_go = out_valid_o & out_ready_i;
  assign out_data_o = mem[rp[AW-1:0]];

  // Storage is written only; no reset needed on data.
  always @(posedge clk_i) begin
    if (wr_go) begin
      mem[wp[AW-1:0]] <= in_data_i;
    end
  end

  // Pointer update.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
    end else begin
      if (wr_go) begin
        wp <= wp + {{AW{1'b0}}, 1'b1};
      end
      if (rd_go) begin
        rp <= rp + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==========================================================
// One counter channel
// ==========================================================

// Inputs arrive already synchronised. Changing a select while
// armed can look like an edge, so reconfigure while idle.
module gpc_chan #(
  parameter CW = `GPC_COUNT_W
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [6:0] sig_i,
  input wire arm_i,
  input wire disarm_i,
  input wire [2:0] mode_i,
  input wire pause_en_i,
  input wire [2:0] src_sel_i,
  input wire [2:0] gate_sel_i,
  input wire [2:0] dir_sel_i,
  input wire src_fall_i,
  input wire gate_low_i,
  input wire [1:0] dir_mode_i,
  input wire push_ready_i,
  input wire ovf_clr_i,
  output reg [CW-1:0] count_o,
  output reg [CW-1:0] save_o,
  output reg push_o,
  output reg ovf_o,
  output wire armed_o,
  output wire done_o
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_RUN = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;
  localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

  reg [3:0] state;
  reg src_d;
  reg act_d;
  wire [7:0] sigs;
  wire src_lv;
  wire act;
  wire dir_up;
  wire s_edge;
  wire act_rise;
  wire act_fall;
  wire is_pw;
  wire up;
  wire [CW-1:0] cnt_inc;
  wire [CW-1:0] cnt_step;

  // Seven inputs selectable; code 7 picks a constant low.
  assign sigs = {1'b0, sig_i}; // see (RL21)
  assign src_lv = sigs[src_sel_i] ^ src_fall_i;
  assign act = sigs[gate_sel_i] ^ gate_low_i;
  assign dir_up = sigs[dir_sel_i];

  // Edge detectors on the polarity-adjusted levels.
  assign s_edge = src_lv & ~src_d; // see (RL2)
  assign act_rise = act & ~act_d; // see (RL6)
  assign act_fall = ~act & act_d;

  // Single semi-period shares the pulse-width path.
  assign is_pw = (mode_i == `GPC_MODE_PW_ONE) |
                 (mode_i == `GPC_MODE_PW_BUF) |
                 (mode_i == `GPC_MODE_SEMI_ONE); // see (RL18)

  // Direction applies to edge counting only.
  assign up = (dir_mode_i == `GPC_DIR_UP) ? 1'b1 :
              (dir_mode_i == `GPC_DIR_DOWN) ? 1'b0 :
              dir_up; // see (RL8)
  assign cnt_inc = count_o + ONE;
  // Plain binary add and subtract wrap on their own.
  assign cnt_step = up ? cnt_inc : count_o - ONE; // see (RL22)

  assign armed_o = state[2] | state[1];
  assign done_o = state[3];

  // Previous levels for the edge detectors.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_d <= 1'b0;
      act_d <= 1'b0;
    end else begin
      src_d <= src_lv;
      act_d <= act;
    end
  end

  // Overflow is sticky; a new overflow beats a clear.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_o <= 1'b0;
    end else if (push_o & ~push_ready_i) begin
      ovf_o <= 1'b1; // see (RL23)
    end else if (ovf_clr_i) begin
      ovf_o <= 1'b0;
    end
  end

  // Main sequencer. The live count is just the register, so
  // reading it never disturbs counting.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      count_o <= `GPC_COUNT_RST; // see (RL3)
      save_o <= `GPC_COUNT_RST;
      push_o <= 1'b0;
    end else begin
      push_o <= 1'b0;
      if (disarm_i) begin
        state <= ST_IDLE;
      end else if (arm_i) begin
        count_o <= `GPC_COUNT_RST;
        // Width and single period wait for a gate edge;
        // the others start counting at the arm itself.
        if (is_pw | (mode_i == `GPC_MODE_PER_ONE)) begin
          state <= ST_WAIT; // see (RL10)
        end else begin
          state <= ST_RUN; // see (RL7) (RL16)
        end
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_IDLE;
          end
          ST_WAIT: begin
            // Only a fresh transition into active starts.
            if (act_rise) begin
              state <= ST_RUN; // see (RL10) (RL13)
              count_o <= `GPC_COUNT_RST;
            end
          end
          ST_RUN: begin
            case (mode_i)
              `GPC_MODE_EDGE: begin
                if (s_edge & ~(pause_en_i & act)) begin
                  count_o <= cnt_step; // see (RL4)
                end
              end
              `GPC_MODE_EDGE_BUF: begin
                if (s_edge) begin
                  count_o <= cnt_step;
                end
                // Sample without clearing the count.
                if (act_rise) begin
                  save_o <= count_o; // see (RL5)
                  push_o <= 1'b1;
                end
              end
              `GPC_MODE_PER_ONE: begin
                if (act_rise) begin
                  save_o <= count_o; // see (RL14)
                  state <= ST_DONE;
                end else if (s_edge) begin
                  count_o <= cnt_inc; // see (RL13) (RL20)
                end
              end
              `GPC_MODE_PER_BUF,
              `GPC_MODE_SEMI_BUF: begin
                // Semi-period closes on either gate edge.
                if (act_rise | ((mode_i == `GPC_MODE_SEMI_BUF)
                    & act_fall)) begin
                  save_o <= count_o; // see (RL15) (RL17)
                  push_o <= 1'b1;
                  // A source edge in the closing cycle
                  // belongs to the next interval.
                  count_o <= s_edge ? ONE : `GPC_COUNT_RST;
                end else if (s_edge) begin
                  count_o <= cnt_inc; // see (RL19)
                end
              end
              default: begin
                // Pulse-width family.
                if (act_fall) begin
                  save_o <= count_o;
                  if (mode_i == `GPC_MODE_PW_BUF) begin
                    push_o <= 1'b1; // see (RL12)
                    state <= ST_WAIT;
                  end else begin
                    state <= ST_DONE; // see (RL11)
                  end
                end else if (s_edge) begin
                  count_o <= cnt_inc; // see (RL9)
                end
              end
            endcase
          end
          ST_DONE: begin
            // Further gate and source edges are ignored.
            state <= ST_DONE;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ==========================================================
// Top level: two channels, synchronisers and queues
// ==========================================================

// Counter n uses bits [7n+6:7n] of the input vector and
// field n of each packed configuration port.
module gpc_top #(
  parameter CW = `GPC_COUNT_W,
  parameter DEPTH = `GPC_FIFO_DEPTH,
  parameter AW = 5
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [13:0] in_sig_i,
  input wire [1:0] arm_i,
  input wire [1:0] disarm_i,
  input wire [5:0] mode_i,
  input wire [1:0] pause_en_i,
  input wire [5:0] src_sel_i,
  input wire [5:0] gate_sel_i,
  input wire [5:0] dir_sel_i,
  input wire [1:0] src_fall_i,
  input wire [1:0] gate_low_i,
  input wire [3:0] dir_mode_i,
  input wire [1:0] ovf_clr_i,
  input wire [1:0] q_ready_i,
  output wire [2*CW-1:0] count_o,
  output wire [2*CW-1:0] save_o,
  output wire [1:0] armed_o,
  output wire [1:0] done_o,
  output wire [1:0] ovf_o,
  output wire [1:0] q_valid_o,
  output wire [2*CW-1:0] q_data_o
);
  reg [13:0] sync1;
  reg [13:0] sync2;

  // Pins and other-domain signals get two flip-flops first.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 14'h0000;
      sync2 <= 14'h0000;
    end else begin
      sync1 <= in_sig_i;
      sync2 <= sync1;
    end
  end

  genvar n;
  generate
    for (n = 0; n < 2; n = n + 1) begin : g_ch
      wire push;
      wire push_ready;
      wire [CW-1:0] save;

      // One independent counter per channel.
      gpc_chan #(.CW(CW)) u_chan ( // see (RL1)
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sig_i(sync2[7*n+6:7*n]),
        .arm_i(arm_i[n]),
        .disarm_i(disarm_i[n]),
        .mode_i(mode_i[3*n+2:3*n]),
        .pause_en_i(pause_en_i[n]),
        .src_sel_i(src_sel_i[3*n+2:3*n]),
        .gate_sel_i(gate_sel_i[3*n+2:3*n]),
        .dir_sel_i(dir_sel_i[3*n+2:3*n]),
        .src_fall_i(src_fall_i[n]),
        .gate_low_i(gate_low_i[n]),
        .dir_mode_i(dir_mode_i[2*n+1:2*n]),
        .push_ready_i(push_ready),
        .ovf_clr_i(ovf_clr_i[n]),
        .count_o(count_o[CW*n+CW-1:CW*n]),
        .save_o(save),
        .push_o(push),
        .ovf_o(ovf_o[n]),
        .armed_o(armed_o[n]),
        .done_o(done_o[n])
      );
      assign save_o[CW*n+CW-1:CW*n] = save;

      // Captures queue in order; a full queue drops the
      // capture and the channel flags it.
      gpc_fifo #(.W(CW), .D(DEPTH), .AW(AW)) u_fifo ( // see (RL23)
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push),
        .in_ready_o(push_ready),
        .in_data_i(save),
        .out_valid_o(q_valid_o[n]),
        .out_ready_i(q_ready_i[n]),
        .out_data_o(q_data_o[CW*n+CW-1:CW*n])
      );
    end
  endgenerate
endmodule

// *** testbench/gpc_monitor.sv ***
// Port checker for the dual counter/timer top.
`timescale 1ns/10ps
// ====
// Checker
// ====
module gpc_monitor #(
  parameter CW = 32
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [1:0] arm_i,
  input wire [1:0] disarm_i,
  input wire [5:0] mode_i,
  input wire [1:0] ovf_clr_i,
  input wire [2*CW-1:0] count_o,
  input wire [2*CW-1:0] save_o,
  input wire [1:0] armed_o,
  input wire [1:0] done_o,
  input wire [1:0] ovf_o
);
  wire [CW-1:0] c0 = count_o[CW-1:0];
  wire [CW-1:0] s0 = save_o[CW-1:0];
  wire go0 = arm_i[0] & ~disarm_i[0];
  // One clock domain, so clocking and reset are stated once.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Counter 0 is watched closely; counter 1 only at its arm.
  a_arm_clears: assert property (go0 |=> c0 == 0)
    else $error("count not cleared by arm");
  a_arm_runs: assert property (go0 |=> armed_o[0] && !done_o[0])
    else $error("arm did not start the counter");
  a_disarm_idle: assert property (
    disarm_i[0] |=> !armed_o[0] && !done_o[0])
    else $error("disarm left the counter busy");
  a_edge_step: assert property (
    mode_i[2:1] == 0 && $past(mode_i[2:1]) == 0 &&
    !$past(arm_i[0] | disarm_i[0]) |->
    c0 - $past(c0) <= 1 || c0 - $past(c0) == {CW{1'b1}})
    else $error("edge count moved by more than one");
  a_done_hold: assert property (
    done_o[0] && !arm_i[0] && !disarm_i[0] |=> $stable(c0) && $stable(s0))
    else $error("finished counter still moving");
  a_edge_nosave: assert property (
    mode_i[2:0] == 0 && $past(mode_i[2:0]) == 0 && !$past(arm_i[0])
    |-> $stable(s0))
    else $error("save changed in edge counting");
  a_ovf_sticky: assert property (
    ovf_o[0] && !ovf_clr_i[0] |=> ovf_o[0])
    else $error("overflow flag dropped");
  a_ch1_arm: assert property (
    arm_i[1] && !disarm_i[1] |=> count_o[2*CW-1:CW] == 0 && armed_o[1])
    else $error("second counter arm failed");
endmodule
bind gpc_top gpc_monitor #(.CW(CW)) i_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .arm_i(arm_i), .disarm_i(disarm_i), .mode_i(mode_i),
  .ovf_clr_i(ovf_clr_i), .count_o(count_o), .save_o(save_o),
  .armed_o(armed_o), .done_o(done_o), .ovf_o(ovf_o));

// *** testbench/gpc_far_end.sv ***
// Model of the terminals and the host side of the counter block.
`timescale 1ns/10ps
// ====
// Far-side model
// ====
module gpc_far_end (
  input wire clk_i,
  input wire rst_n_i,
  input wire src_i,
  input wire gate_i,
  input wire dir_i,
  input wire stall_i,
  output wire [13:0] in_sig_o,
  output reg [1:0] q_ready_o
);
  reg [1:0] phase;
  // Timebase on source, measured signal on gate; spare inputs low.
  assign in_sig_o = {4'h0, dir_i, gate_i, src_i,
    4'h0, dir_i, gate_i, src_i};
  // Host takes words two cycles in three and none while stalled, so
  // the queue sees prompt and slow draining alike.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= 2'h0;
      q_ready_o <= 2'h0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      q_ready_o <= (stall_i || phase == 2'h0) ? 2'h0 : 2'h3;
    end
  end
endmodule

// *** testbench/gpc_top_tb_top.sv ***
// Self-checking bench for the dual counter/timer top.
`timescale 1ns/10ps
// ====
// Bench top
// ====
module gpc_top_tb_top;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg src = 1'b0;
  reg gate = 1'b0;
  reg dir = 1'b0;
  reg stall = 1'b0;
  reg [1:0] arm = 2'h0, dis = 2'h0, pen = 2'h0;
  reg [1:0] sfall = 2'h0, glow = 2'h0, oclr = 2'h0;
  reg [5:0] mode = 6'h00;
  reg [3:0] dmode = 4'h0;
  reg [5:0] ssel = 6'h00;
  wire [13:0] sig;
  wire [1:0] qrdy, armed, done, ovf, qv;
  wire [63:0] cnt, sav, qd;
  integer seed = 32'h0468BE78;
  integer err_total = 0;
  integer n_checks = 0;
  integer tot = 0;
  integer i, n, m, k;
  reg [31:0] expq [$];
  gpc_far_end i_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .src_i(src),
    .gate_i(gate), .dir_i(dir), .stall_i(stall), .in_sig_o(sig),
    .q_ready_o(qrdy));
  gpc_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .in_sig_i(sig),
    .arm_i(arm), .disarm_i(dis), .mode_i(mode), .pause_en_i(pen),
    .src_sel_i(ssel), .gate_sel_i(6'h09), .dir_sel_i(6'h12),
    .src_fall_i(sfall), .gate_low_i(glow), .dir_mode_i(dmode),
    .ovf_clr_i(oclr), .q_ready_i(qrdy), .count_o(cnt), .save_o(sav),
    .armed_o(armed), .done_o(done), .ovf_o(ovf), .q_valid_o(qv),
    .q_data_o(qd));
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task tick(input integer c);
    repeat (c) @(posedge clk_i);
  endtask
  // Automatic, because the queue watcher calls it concurrently.
  task automatic chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  function [31:0] f_edge(input up, input integer c);
    f_edge = up ? c : -c;
  endfunction
  // Source pulses keep two cycles per level, twice the one-cycle closest spacing allowed.
  task pulse(input integer c);
    begin
      repeat (c) begin
        src <= 1'b1;
        tick(2);
        src <= 1'b0;
        tick(2);
      end
      tot = tot + c;
      tick(3);
    end
  endtask
  task setg(input v);
    begin
      gate <= v;
      tick(5);
    end
  endtask
  task go(input [2:0] md);
    begin
      mode[2:0] <= md;
      dis[0] <= 1'b0;
      arm[0] <= 1'b1;
      tick(1);
      arm[0] <= 1'b0;
      tick(1);
    end
  endtask
  task drain;
    begin
      for (i = 0; i < 500 && expq.size() != 0; i = i + 1)
        tick(1);
      chk("drain", 32'h0, expq.size());
      if (expq.size() != 0)
        tally_and_finish;
    end
  endtask
  task tally_and_finish;
    begin
      if (err_total == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Every word the host takes must be the oldest expected capture.
  always @(posedge clk_i) begin
    if (qv[0] & qrdy[0]) begin
      if (expq.size() == 0)
        chk("qextra", 32'h0, 32'h1);
      else
        chk("qword", expq.pop_front(), qd[31:0]);
    end
  end
  // Main sequence.
  initial begin
    tick(3);
    rst_n_i <= 1'b1;
    arm[1] <= 1'b1;
    tick(1);
    arm[1] <= 1'b0;
    // Every direction code; the two follow codes see dir low.
    for (k = 0; k < 4; k = k + 1) begin
      dmode[1:0] <= k[1:0];
      n = 1 + {$random(seed)} % 20;
      go(0);
      pulse(n);
      chk("edge", f_edge(k == 0, n), cnt[31:0]);
    end
    dir <= 1'b1;
    pulse(3);
    chk("dirpin", f_edge(0, n - 3), cnt[31:0]);
    sfall[0] <= 1'b1;
    go(0);
    src <= 1'b1;
    tick(5);
    chk("fall", 32'h0, cnt[31:0]);
    src <= 1'b0;
    tick(5);
    chk("fall", 32'h1, cnt[31:0]);
    sfall[0] <= 1'b0;
    tot = tot + 1;
    pen[0] <= 1'b1;
    go(0);
    setg(1);
    pulse(3);
    setg(0);
    pulse(2);
    chk("pause", 32'h2, cnt[31:0]);
    pen[0] <= 1'b0;
    // Select code 7 is the constant low input, so nothing counts.
    ssel[2:0] <= 3'h7;
    go(0);
    pulse(2);
    chk("spare", 32'h0, cnt[31:0]);
    ssel[2:0] <= 3'h0;
    for (k = 0; k < 2; k = k + 1) begin
      dis[0] <= 1'b1;
      glow[0] <= k[0];
      setg(k[0]);
      n = 1 + {$random(seed)} % 9;
      m = 1 + {$random(seed)} % 9;
      go(1);
      pulse(n);
      expq.push_back(n);
      setg(!k[0]);
      pulse(m);
      setg(k[0]);
      expq.push_back(n + m);
      setg(!k[0]);
      chk("cumul", n + m, cnt[31:0]);
    end
    dis[0] <= 1'b1;
    glow[0] <= 1'b0;
    setg(0);
    for (k = 2; k < 7; k = k + 4) begin
      setg(1);
      go(k[2:0]);
      pulse(3);
      setg(0);
      chk("late", 32'h0, {31'h0, done[0]});
      setg(1);
      n = 1 + {$random(seed)} % 20;
      pulse(n);
      setg(0);
      pulse(2);
      chk("width", n, sav[31:0]);
      chk("done", 32'h1, {31'h0, done[0]});
    end
    go(3);
    for (k = 0; k < 3; k = k + 1) begin
      setg(1);
      n = 1 + {$random(seed)} % 20;
      pulse(n);
      expq.push_back(n);
      setg(0);
    end
    go(4);
    pulse(2);
    setg(1);
    n = 1 + {$random(seed)} % 20;
    pulse(n);
    setg(0);
    setg(1);
    chk("period", n, sav[31:0]);
    chk("pdone", 32'h1, {31'h0, done[0]});
    setg(0);
    // Each gate interval holds at least one source pulse.
    for (k = 5; k < 8; k = k + 2) begin
      dis[0] <= 1'b1;
      setg(0);
      go(k[2:0]);
      n = 1 + {$random(seed)} % 9;
      m = 1 + {$random(seed)} % 9;
      pulse(n);
      expq.push_back(n);
      setg(1);
      pulse(m);
      if (k == 7)
        expq.push_back(m);
      setg(0);
      pulse(n);
      expq.push_back((k == 7) ? n : n + m);
      setg(1);
    end
    drain;
    dis[0] <= 1'b1;
    setg(0);
    stall <= 1'b1;
    go(1);
    for (k = 0; k < 34; k = k + 1) begin
      if (k < 32)
        expq.push_back(0);
      setg(1);
      setg(0);
    end
    chk("ovf", 32'h1, {31'h0, ovf[0]});
    stall <= 1'b0;
    drain;
    oclr[0] <= 1'b1;
    tick(2);
    oclr[0] <= 1'b0;
    tick(2);
    chk("ovfclr", 32'h0, {31'h0, ovf[0]});
    chk("second", tot, cnt[63:32]);
    // The second counter only counted edges: armed, nothing else.
    chk("ch1", 32'h1, {28'h0, qv[1], ovf[1], done[1], armed[1]});
    chk("ch1save", 32'h0, sav[63:32]);
    tally_and_finish;
  end
endmodule
